// File: verilog/spc_pkg.sv
// Purpose: Shared constants and types for the serial port setup block.
// Assumes: One 200 MHz clock; registers reached over classic Wishbone.
// Notes:   Byte address of a register is four times its index.
package spc_pkg;

  // ==========================================================
  // Clock and timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TMO_UNIT_MS = 100; // Timeout step
  localparam int unsigned TMO_DEF_S = 5; // Timeout for code 00
  localparam int unsigned TMO_DEF_UNITS = TMO_DEF_S * 1000 / TMO_UNIT_MS;
  localparam int unsigned TMO_UNIT_CYC = CLK_HZ / 1000 * TMO_UNIT_MS;

  // ==========================================================
  // Register indices
  localparam logic [7:0] IDX_FRAME = 8'hA0;
  localparam logic [7:0] IDX_SPEED = 8'hA1;
  localparam logic [7:0] IDX_TMO = 8'hA7;
  localparam logic [7:0] IDX_CTRL = 8'hA8;
  localparam logic [7:0] IDX_STAT = 8'hA9;
  localparam logic [7:0] IDX_MASK = 8'hAA;

  // ==========================================================
  // Field positions and reset values
  localparam int unsigned PAR_LSB = 0;
  localparam int unsigned MODE_LSB = 8;
  localparam int unsigned SEL_BIT = 15;
  localparam int unsigned BAUD_LSB = 0;
  localparam int unsigned TMO_LSB = 8;
  localparam int unsigned CTRL_APPLY = 0;
  localparam int unsigned ST_TIMEOUT = 0;
  localparam int unsigned ST_APPLIED = 1;
  localparam int unsigned ST_RESP = 2;
  localparam int unsigned ST_W = 3;
  localparam logic [15:0] FRAME_RST = 16'h0000;
  localparam logic [15:0] SPEED_RST = 16'h0000;
  localparam logic [15:0] TMO_RST = 16'h0000;
  localparam logic [ST_W-1:0] MASK_RST = 3'h0;

  // ==========================================================
  // Codes
  localparam logic [3:0] MODE_HOST_LINK = 4'h0;
  localparam logic [3:0] MODE_POLL_MASTER = 4'h8;
  localparam logic [3:0] MODE_GATEWAY = 4'h9;
  localparam logic [7:0] BAUD_MAX = 8'h0A;
  localparam logic [7:0] BAUD_LINK_HIGH = 8'h0A;
  localparam logic [7:0] TMO_CODE_DEF = 8'h00;
  localparam logic [15:0] END_CODE_TIMEOUT = 16'h0205;
  localparam int unsigned RATE_BPS [0:10] = '{9600, 300, 600, 1200, 2400,
    4800, 9600, 19200, 38400, 57600, 115200};
  localparam int unsigned STD_BPS = 9600;
  localparam int unsigned LINK_STD_BPS = 38400;
  localparam int unsigned LINK_HI_BPS = 115200;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {PAR_EVEN, PAR_ODD, PAR_NONE} spc_parity_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } spc_wb_req_t;

  typedef struct packed {
    spc_parity_t parity;
    logic [7:0] baud_code;
    logic gateway;
    logic link_master;
    logic link_high;
  } spc_cfg_t;

endpackage

// File: verilog/spc_top.sv
// Purpose: Serial port setup registers, effective settings, baud enable
//          and gateway response timer.
// Assumes: Cycle and gateway strobes come from logic on clk_i.
// Notes:   Frame, speed and timeout writes land in staging registers until the next scan cycle or change command.
//
// Summary of operation
// - Parity field bits 1:0 decode 00 even, 01 odd, 10 none, even by default.
// - Baud codes 01 to 0A pick 300 up to 115200 bit/s, code 00 picks 9600.
// - Parity fields count only in host command protocol mode, baud fields also as polling master.
// - In host command protocol mode, parity and baud fields count only when the custom selection bit is 1.
// - A changed setting takes effect from the next cycle or on the change command.
// - Timeout byte 00 gives 5 s and codes 01 to FF give code times 100 ms.
// - The timer starts when the gateway command is sent and stops on its response.
// - On expiry the end code 0205 hex goes back to the command originator.
// - Mode field value 8 makes the port the polling master of the shared link.
// - As polling master baud code 00 means standard and 0A high link speed.
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/1ps

module spc_top #(
  parameter int unsigned TMO_UNIT_CYC = spc_pkg::TMO_UNIT_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input spc_pkg::spc_wb_req_t wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Scan cycle boundary and gateway events
  input wire logic cycle_tick_i,
  input wire logic gw_cmd_sent_i,
  input wire logic gw_resp_rcvd_i,
  // Effective settings and bit rate enable
  output spc_pkg::spc_cfg_t cfg_o,
  output logic baud_tick_o,
  output logic change_pending_o,
  // Gateway timeout answer
  output logic gw_busy_o,
  output logic gw_timeout_o,
  output logic [15:0] gw_end_code_o,
  // Interrupt
  output logic irq_o
);

  // ==========================================================
  // Helpers
  function automatic logic [31:0] adr_of(input logic [7:0] idx);
    adr_of = {22'h0, idx, 2'b00};
  endfunction

  function automatic logic [19:0] div_of(input int unsigned bps);
    div_of = 20'(spc_pkg::CLK_HZ / bps);
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
    merge = old;
    if (sel[0]) begin
      merge[7:0] = dat[7:0];
    end
    if (sel[1]) begin
      merge[15:8] = dat[15:8];
    end
  endfunction

  // ==========================================================
  // Bus decode
  logic req;
  logic wr;
  logic rd;
  assign req = wb_i.cyc && wb_i.stb && !wb_ack_o;
  assign wr = req && wb_i.we;
  assign rd = req && !wb_i.we;

  // ==========================================================
  // Registers
  logic [15:0] frame_q, frame_d;
  logic [15:0] speed_q, speed_d;
  logic [15:0] tmo_q, tmo_d;
  logic [15:0] frame_act_q, frame_act_d;
  logic [15:0] speed_act_q, speed_act_d;
  logic [15:0] tmo_act_q, tmo_act_d;
  logic pend_q, pend_d;
  logic [spc_pkg::ST_W-1:0] stat_q, stat_d;
  logic [spc_pkg::ST_W-1:0] mask_q, mask_d;
  logic [31:0] rdat_d;
  logic ack_d;
  logic apply;
  logic [spc_pkg::ST_W-1:0] ev;

  // Staging, apply and status; event set wins over read clear
  always_comb begin
    frame_d = frame_q;
    speed_d = speed_q;
    tmo_d = tmo_q;
    mask_d = mask_q;
    pend_d = pend_q;
    rdat_d = 32'h0;
    ack_d = req;
    apply = pend_q && cycle_tick_i;
    if (wr) begin
      case (wb_i.adr)
        adr_of(spc_pkg::IDX_FRAME): begin
          frame_d = merge(frame_q, wb_i.dat, wb_i.sel);
          pend_d = 1'b1;
        end
        adr_of(spc_pkg::IDX_SPEED): begin
          speed_d = merge(speed_q, wb_i.dat, wb_i.sel);
          pend_d = 1'b1;
        end
        adr_of(spc_pkg::IDX_TMO): begin
          tmo_d = merge(tmo_q, wb_i.dat, wb_i.sel);
          pend_d = 1'b1;
        end
        adr_of(spc_pkg::IDX_CTRL): begin
          // Settings change instruction forces an apply now
          if (wb_i.sel[0] && wb_i.dat[spc_pkg::CTRL_APPLY]) begin
            apply = 1'b1;
          end
        end
        adr_of(spc_pkg::IDX_MASK): begin
          if (wb_i.sel[0]) begin
            mask_d = wb_i.dat[spc_pkg::ST_W-1:0];
          end
        end
        default: begin
        end
      endcase
    end
    if (rd) begin
      case (wb_i.adr)
        adr_of(spc_pkg::IDX_FRAME): rdat_d = {16'h0, frame_q};
        adr_of(spc_pkg::IDX_SPEED): rdat_d = {16'h0, speed_q};
        adr_of(spc_pkg::IDX_TMO): rdat_d = {16'h0, tmo_q};
        adr_of(spc_pkg::IDX_CTRL): rdat_d = {31'h0, pend_q};
        adr_of(spc_pkg::IDX_STAT): rdat_d = {29'h0, stat_q};
        adr_of(spc_pkg::IDX_MASK): rdat_d = {29'h0, mask_q};
        default: rdat_d = 32'h0; // Unmapped reads as zero
      endcase
    end
    // A fresh write in the applying cycle is applied with the rest and pending clears
    if (apply && !(wr && wb_i.adr != adr_of(spc_pkg::IDX_CTRL)
                   && wb_i.adr != adr_of(spc_pkg::IDX_MASK)
                   && pend_d && !pend_q)) begin
      pend_d = 1'b0;
    end
    frame_act_d = apply ? frame_d : frame_act_q;
    speed_act_d = apply ? speed_d : speed_act_q;
    tmo_act_d = apply ? tmo_d : tmo_act_q;
    stat_d = stat_q;
    if (rd && wb_i.adr == adr_of(spc_pkg::IDX_STAT)) begin
      stat_d = '0;
    end
    stat_d = stat_d | ev;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame_q <= spc_pkg::FRAME_RST;
      speed_q <= spc_pkg::SPEED_RST;
      tmo_q <= spc_pkg::TMO_RST;
      frame_act_q <= spc_pkg::FRAME_RST;
      speed_act_q <= spc_pkg::SPEED_RST;
      tmo_act_q <= spc_pkg::TMO_RST;
      pend_q <= 1'b0;
      stat_q <= '0;
      mask_q <= spc_pkg::MASK_RST;
      wb_dat_o <= 32'h0;
      wb_ack_o <= 1'b0;
    end else begin
      frame_q <= frame_d;
      speed_q <= speed_d;
      tmo_q <= tmo_d;
      frame_act_q <= frame_act_d;
      speed_act_q <= speed_act_d;
      tmo_act_q <= tmo_act_d;
      pend_q <= pend_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      wb_dat_o <= rdat_d;
      wb_ack_o <= ack_d;
    end
  end

  assign change_pending_o = pend_q;
  assign irq_o = |(stat_q & mask_q);

  // ==========================================================
  // Effective settings
  spc_pkg::spc_cfg_t cfg_d;
  logic [19:0] div_d, div_q;
  logic [3:0] mode;
  logic [1:0] par_f;
  logic [7:0] baud_f;
  logic custom;
  assign mode = frame_act_q[spc_pkg::MODE_LSB +: 4];
  assign par_f = frame_act_q[spc_pkg::PAR_LSB +: 2];
  assign custom = frame_act_q[spc_pkg::SEL_BIT];
  assign baud_f = speed_act_q[spc_pkg::BAUD_LSB +: 8];

  // Non-custom or other modes except polling master fall back to even parity at 9600
  always_comb begin
    cfg_d.parity = spc_pkg::PAR_EVEN;
    cfg_d.baud_code = 8'h00;
    cfg_d.gateway = (mode == spc_pkg::MODE_GATEWAY);
    cfg_d.link_master = (mode == spc_pkg::MODE_POLL_MASTER);
    cfg_d.link_high = 1'b0;
    div_d = div_of(spc_pkg::STD_BPS);
    if (mode == spc_pkg::MODE_HOST_LINK && custom) begin
      case (par_f)
        2'h1: cfg_d.parity = spc_pkg::PAR_ODD;
        2'h2: cfg_d.parity = spc_pkg::PAR_NONE;
        default: cfg_d.parity = spc_pkg::PAR_EVEN;
      endcase
      if (baud_f <= spc_pkg::BAUD_MAX) begin
        cfg_d.baud_code = baud_f;
        div_d = div_of(spc_pkg::RATE_BPS[baud_f[3:0]]);
      end
    end
    if (cfg_d.link_master) begin
      // Polled nodes must be set to this same speed
      cfg_d.link_high = (baud_f == spc_pkg::BAUD_LINK_HIGH);
      cfg_d.baud_code = baud_f;
      div_d = cfg_d.link_high ? div_of(spc_pkg::LINK_HI_BPS)
                              : div_of(spc_pkg::LINK_STD_BPS);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_o <= '0;
      div_q <= div_of(spc_pkg::STD_BPS);
    end else begin
      cfg_o <= cfg_d;
      div_q <= div_d;
    end
  end

  // ==========================================================
  // Bit rate enable divider
  logic [19:0] bcnt_q, bcnt_d;
  logic btick_d;

  // Restart the count if a new divisor makes it overshoot
  always_comb begin
    btick_d = 1'b0;
    bcnt_d = bcnt_q + 20'h1;
    if (bcnt_q >= div_q - 20'h1) begin
      bcnt_d = 20'h0;
      btick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcnt_q <= 20'h0;
      baud_tick_o <= 1'b0;
    end else begin
      bcnt_q <= bcnt_d;
      baud_tick_o <= btick_d;
    end
  end

  // ==========================================================
  // Gateway response timer
  logic [31:0] ucnt_q, ucnt_d;
  logic [7:0] units_q, units_d;
  logic run_q, run_d;
  logic tmo_d_o;
  logic [7:0] code;
  logic [7:0] limit;
  assign code = tmo_act_q[spc_pkg::TMO_LSB +: 8];
  assign limit = (code == spc_pkg::TMO_CODE_DEF) ?
                 8'(spc_pkg::TMO_DEF_UNITS) : code;

  // Counts whole 100 ms units; a new send restarts the wait
  always_comb begin
    ucnt_d = ucnt_q;
    units_d = units_q;
    run_d = run_q;
    tmo_d_o = 1'b0;
    ev = '0;
    ev[spc_pkg::ST_APPLIED] = apply;
    if (run_q) begin
      if (ucnt_q == TMO_UNIT_CYC - 1) begin
        ucnt_d = 32'h0;
        units_d = units_q + 8'h1;
        if (units_q + 8'h1 >= limit) begin
          run_d = 1'b0;
          tmo_d_o = 1'b1;
        end
      end else begin
        ucnt_d = ucnt_q + 32'h1;
      end
    end
    if (run_q && gw_resp_rcvd_i) begin
      run_d = 1'b0;
      tmo_d_o = 1'b0;
      ev[spc_pkg::ST_RESP] = 1'b1;
    end
    if (gw_cmd_sent_i && cfg_o.gateway) begin
      run_d = 1'b1;
      ucnt_d = 32'h0;
      units_d = 8'h0;
      tmo_d_o = 1'b0;
    end
    ev[spc_pkg::ST_TIMEOUT] = tmo_d_o;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ucnt_q <= 32'h0;
      units_q <= 8'h0;
      run_q <= 1'b0;
      gw_timeout_o <= 1'b0;
      gw_end_code_o <= 16'h0000;
    end else begin
      ucnt_q <= ucnt_d;
      units_q <= units_d;
      run_q <= run_d;
      gw_timeout_o <= tmo_d_o;
      if (tmo_d_o) begin
        gw_end_code_o <= spc_pkg::END_CODE_TIMEOUT;
      end
    end
  end

  assign gw_busy_o = run_q;

endmodule // spc_top

// File: testbench/spc_sva.sv
// Purpose: Port assertions for the setup block.
// Assumes: One clock, sync reset.
// Notes:   Bound into spc_top below.
`timescale 1ns/1ps
module spc_sva #(
  parameter int unsigned TMO_UNIT_CYC = 10
) (
  // Inputs of the block
  input wire logic clk_i,
  input wire logic rst_i,
  input spc_pkg::spc_wb_req_t wb_i,
  input wire logic cycle_tick_i,
  input wire logic gw_cmd_sent_i,
  input wire logic gw_resp_rcvd_i,
  // Outputs of the block
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input spc_pkg::spc_cfg_t cfg_o,
  input wire logic baud_tick_o,
  input wire logic change_pending_o,
  input wire logic gw_busy_o,
  input wire logic gw_timeout_o,
  input wire logic [15:0] gw_end_code_o,
  input wire logic irq_o
);
  // ==========================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_ONE: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  AST_MODE_EXCL: assert property (cfg_o.link_master |-> !cfg_o.gateway)
    else $error("two modes");
  AST_HOST_ONLY: assert property (cfg_o.gateway |-> cfg_o.parity == spc_pkg::PAR_EVEN)
    else $error("parity outside host mode");
  AST_HIGH_LINK: assert property (cfg_o.link_high |-> cfg_o.link_master)
    else $error("high speed without master");
  AST_APPLY: assert property (cycle_tick_i && change_pending_o |-> ##[1:2] !change_pending_o)
    else $error("pending not cleared");
  AST_END_CODE: assert property (gw_timeout_o |->
    gw_end_code_o == spc_pkg::END_CODE_TIMEOUT && !gw_busy_o) else $error("bad end code");
  AST_START: assert property (gw_cmd_sent_i && cfg_o.gateway |=> gw_busy_o)
    else $error("timer not started");
  AST_STOP: assert property (gw_busy_o && gw_resp_rcvd_i && !gw_cmd_sent_i |=>
    !gw_busy_o && !gw_timeout_o) else $error("timer not stopped");
  // Shortest limit is one step, so busy stood at least ten cycles
  AST_TMO_MIN: assert property (gw_timeout_o |-> $past(gw_busy_o, 10))
    else $error("timeout too early");
endmodule // spc_sva
bind spc_top spc_sva #(.TMO_UNIT_CYC(TMO_UNIT_CYC)) i_spc_sva (.clk_i(clk_i), .rst_i(rst_i),
  .wb_i(wb_i), .cycle_tick_i(cycle_tick_i), .gw_cmd_sent_i(gw_cmd_sent_i),
  .gw_resp_rcvd_i(gw_resp_rcvd_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cfg_o(cfg_o),
  .baud_tick_o(baud_tick_o), .change_pending_o(change_pending_o), .gw_busy_o(gw_busy_o),
  .gw_timeout_o(gw_timeout_o), .gw_end_code_o(gw_end_code_o), .irq_o(irq_o));

// File: testbench/spc_peer.sv
// Purpose: Far end that answers gateway commands.
// Assumes: Same clock as the block.
// Notes:   A silent peer lets the timer run out.
`timescale 1ns/1ps
module spc_peer (
  // Clock and control
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sent_i,
  input wire logic answer_i,
  input wire logic [7:0] dly_i,
  // Polled node's own link speed and the master's settings
  input wire logic node_high_i,
  input spc_pkg::spc_cfg_t cfg_i,
  // Response pulse and link speed mismatch
  output logic resp_o,
  output logic link_fault_o
);
  logic [7:0] cnt_q;
  logic run_q;
  // Count down the reply delay, answer only what was asked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_q <= 1'b0;
      cnt_q <= 8'h00;
      resp_o <= 1'b0;
    end else if (sent_i && answer_i) begin
      run_q <= 1'b1;
      cnt_q <= dly_i;
      resp_o <= 1'b0;
    end else begin
      cnt_q <= run_q ? cnt_q - 8'h01 : cnt_q;
      run_q <= run_q && cnt_q != 8'h00;
      resp_o <= run_q && cnt_q == 8'h00;
    end
  end
  // A polled node is set up to run the master's link speed
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_fault_o <= 1'b0;
    end else begin
      link_fault_o <= cfg_i.link_master && (cfg_i.link_high != node_high_i);
    end
  end
endmodule // spc_peer

// File: testbench/tb.sv
// Purpose: Self-checking bench for spc_top.
// Assumes: Short timer step of 10 cycles.
// Notes:   Reads and timeouts are checked from one queue.
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module tb;
  localparam int unsigned U = 10;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  spc_pkg::spc_wb_req_t wb = '0;
  logic tick = 1'b0;
  logic sent = 1'b0;
  logic ans = 1'b0;
  logic node_high = 1'b0;
  logic resp, ack, pend, busy, tmo, irq, btick, link_fault;
  logic [31:0] rdat, exp_v;
  logic [15:0] ecode;
  logic [1:0] p;
  spc_pkg::spc_cfg_t cfg, e;
  logic [31:0] q[$];
  logic [31:0] seed = 32'h6F45D79D;
  // Frame word, speed word, expected {parity, gateway, master, high}
  logic [28:0] mt [4] = '{{16'h0002, 8'h05, 5'h00}, {16'h8801, 8'h0A, 5'h03},
    {16'h0800, 8'h00, 5'h02}, {16'h8901, 8'h70, 5'h04}};
  int n_mismatch = 0;
  int cmp_count = 0;
  // ==========================
  // Clock, design and peer
  always #2.5 clk_i = ~clk_i;
  spc_top #(.TMO_UNIT_CYC(U)) i_spc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb),
    .wb_dat_o(rdat), .wb_ack_o(ack), .cycle_tick_i(tick), .gw_cmd_sent_i(sent),
    .gw_resp_rcvd_i(resp), .cfg_o(cfg), .baud_tick_o(btick), .change_pending_o(pend),
    .gw_busy_o(busy), .gw_timeout_o(tmo), .gw_end_code_o(ecode), .irq_o(irq));
  spc_peer i_spc_peer (.clk_i(clk_i), .rst_i(rst_i), .sent_i(sent), .answer_i(ans),
    .dly_i(8'h05), .node_high_i(node_high), .cfg_i(cfg), .resp_o(resp),
    .link_fault_o(link_fault));
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // One classic cycle, held until ack is sampled
  task automatic bus(input logic [7:0] i, input logic w, input logic [31:0] d);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: {22'h0, i, 2'h0}, dat: d};
    // No fixed wait assumed; only the watchdog ends a hang
    do @(posedge clk_i); while (ack !== 1'b1);
    wb <= '0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] x);
    q.push_back(x);
    bus(i, 1'b0, 32'h0);
  endtask
  // Cycles between two bit rate pulses, after the first one seen
  task automatic gap(input int n);
    int k = 0;
    do @(posedge clk_i); while (btick !== 1'b1);
    do begin @(posedge clk_i); k++; end while (btick !== 1'b1 && k < n + 9);
    `CHK("baud gap", n, k)
  endtask
  // Apply by cycle boundary or by the change command
  task automatic apply(input logic f);
    if (f) begin
      tick <= 1'b1;
      @(posedge clk_i);
      tick <= 1'b0;
    end else bus(spc_pkg::IDX_CTRL, 1'b1, 32'h1);
    repeat (3) @(posedge clk_i);
  endtask
  // Send one command, count cycles to the timeout pulse
  task automatic gw(input logic a, input int lim);
    int k = 0;
    ans <= a;
    if (!a) q.push_back(32'h205);
    sent <= 1'b1;
    @(posedge clk_i);
    sent <= 1'b0;
    do begin @(posedge clk_i); k++; end while (tmo !== 1'b1 && k < lim + 40);
    `CHK("tmo cycles", a ? lim + 40 : lim, k)
  endtask
  // Result watcher takes the oldest note
  always @(posedge clk_i) begin
    if (!rst_i && ((ack && !wb.we) || tmo)) begin
      exp_v = q.size() ? q.pop_front() : 32'hX;
      `CHK("result", exp_v, ack ? rdat : {16'h0, ecode})
    end
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog well past the expected run
  initial begin
    #100000;
    n_mismatch++;
    results();
  end
  // Main sequence
  initial begin
    e = '0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("cfg reset", 14'h0, {pend, cfg})
    rd(spc_pkg::IDX_FRAME, 32'h0);
    rd(spc_pkg::IDX_SPEED, 32'h0);
    rd(spc_pkg::IDX_TMO, 32'h0);
    rd(8'h10, 32'h0);
    $display("test regs done");
    for (int c = 0; c <= 10; c++) begin
      seed = lf(seed);
      p = seed[1:0];
      bus(spc_pkg::IDX_FRAME, 1'b1, {24'h80, 6'h0, p});
      bus(spc_pkg::IDX_SPEED, 1'b1, 32'(c));
      `CHK("held", {1'b1, e}, {pend, cfg})
      e = '{parity: spc_pkg::spc_parity_t'(p == 2'h3 ? 2'h0 : p), baud_code: 8'(c),
        gateway: 1'b0, link_master: 1'b0, link_high: 1'b0};
      apply(c[0]);
      `CHK("cfg", {1'b0, e}, {pend, cfg})
      if (c == 10) gap(spc_pkg::CLK_HZ / spc_pkg::RATE_BPS[10]);
    end
    $display("test codes done");
    for (int r = 0; r < 4; r++) begin
      node_high <= mt[r][0];
      bus(spc_pkg::IDX_FRAME, 1'b1, {16'h0, mt[r][28:13]});
      bus(spc_pkg::IDX_SPEED, 1'b1, {24'h0, mt[r][12:5]});
      apply(1'b1);
      `CHK("mode", mt[r][4:0], {cfg.parity, cfg.gateway, cfg.link_master, cfg.link_high})
      `CHK("link fault", 1'b0, link_fault)
      if (r == 1) gap(spc_pkg::CLK_HZ / spc_pkg::LINK_HI_BPS);
    end
    $display("test modes done");
    rd(spc_pkg::IDX_STAT, 32'h2);
    bus(spc_pkg::IDX_TMO, 1'b1, 32'h0300);
    apply(1'b1);
    gw(1'b0, 3 * U + 1);
    `CHK("irq masked", 1'b0, irq)
    bus(spc_pkg::IDX_MASK, 1'b1, 32'h1);
    `CHK("irq", 1'b1, irq)
    rd(spc_pkg::IDX_STAT, 32'h3);
    `CHK("irq cleared", 1'b0, irq)
    gw(1'b1, 3 * U + 1);
    rd(spc_pkg::IDX_STAT, 32'h4);
    bus(spc_pkg::IDX_TMO, 1'b1, 32'h0);
    apply(1'b0);
    gw(1'b0, spc_pkg::TMO_DEF_UNITS * U + 1);
    `CHK("irq again", 1'b1, irq)
    $display("test timer done");
    results();
  end
endmodule // tb
